// [dual_pll_synth_control.sv]
// Digital control core of a dual integer-N frequency synthesizer.
//
// ----------------------------------------------------------------------------
// Overview of operation
// - One reference input drives both reference dividers together.
// - Reference dividers are 15-bit counters dividing by 2 to 32767.
// - Each prescaler offers two dual moduli chosen by loop rating.
// - Feedback counter runs on prescaler output: 13-bit integer, 5-bit swallow.
// - Feedback divider covers the continuous ranges of each modulus.
// - Detector compares reference and feedback outputs; polarity bit picks direction.
// - Pump drives up or down, otherwise stays high impedance.
// - Boost bit selects 1 mA when clear and 4 mA when set.
// - Serial data enters MSB first into 22-bit register on clock rise.
// - Load strobe rise copies shift register into latch picked by low bits.
// - Serial port shifts and latches in every power-down combination.
// - Multifunction pin shows fast acquisition, CMOS level, lock or status.
// - Lock detect is high while pump idle, low while pump active.
// - A powered-down loop always reports lock detect high.
// - Fast acquisition turns the open-drain output on while boost commanded and the loop powered up.
// - Loop power-down stops its dividers and de-biases its RF input.
// - Reference input powers down only when both loops are powered down.
// - Power-down holds pump and detector off and dividers in reset.
// - Feedback divider restarts aligned with reference divider within one cycle.
// - Serial word is 20 data bits above a 2-bit address.
// - Address 0 aux ref, 1 aux feedback, 2 main ref, 3 main feedback.
// ----------------------------------------------------------------------------
`include "synth_defines.svh"
`default_nettype none
module dual_pll_synth_control
   import synth_pkg::*;
#(
   parameter bit MAIN_HIGH_RATE = 1'b1,
   parameter bit AUX_HIGH_RATE  = 1'b0
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic reference_input,
   input  wire logic main_rf_input,
   input  wire logic aux_rf_input,
   input  wire logic serial_clock,
   input  wire logic serial_data,
   input  wire logic load_strobe,
   output var  logic main_pump_up,
   output var  logic main_pump_down,
   output var  logic main_pump_current_boost,
   output var  logic aux_pump_up,
   output var  logic aux_pump_down,
   output var  logic aux_pump_current_boost,
   output var  logic main_rf_input_enable,
   output var  logic aux_rf_input_enable,
   output var  logic reference_input_enable,
   output var  logic multifunction_output_o,
   output var  logic multifunction_output_oe
);

   // ----------------------------------------------------------------------------
   // Field helpers
   // ----------------------------------------------------------------------------
   // Ratios below the minimum are raised to it so the divider never stalls.
   function automatic logic [`REF_CNT_W-1:0] ref_ratio(input logic [`DATA_W-1:0] d);
      logic [`REF_CNT_W-1:0] r;
      r = d[`F_RCNT_HI:0];
      if (r < `REF_RATIO_MIN) begin
         r = `REF_RATIO_MIN;
      end
      return r;
   endfunction

   function automatic logic pump_active(input pfd_state_t s);
      return s != PFD_IDLE;
   endfunction

   // ----------------------------------------------------------------------------
   // Serial port
   // ----------------------------------------------------------------------------
   logic [`SHIFT_W-1:0] shift_r;
   logic                sclk_prev_r;
   logic                le_prev_r;
   logic [`DATA_W-1:0]  latch_r [4];
   logic                sclk_rise;
   logic                le_rise;

   assign sclk_rise = serial_clock & ~sclk_prev_r;
   assign le_rise   = load_strobe & ~le_prev_r;

   // Edge detectors reset low, the idle level of both lines.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sclk_prev_r <= 1'b0;
         le_prev_r   <= 1'b0;
      end else begin
         sclk_prev_r <= serial_clock;
         le_prev_r   <= load_strobe;
      end
   end

   // Shifting is never gated by the power-down bits.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shift_r <= '0;
      end else if (sclk_rise) begin
         shift_r <= {shift_r[`SHIFT_W-2:0], serial_data};
      end
   end

   // ----------------------------------------------------------------------------
   // Latches
   // ----------------------------------------------------------------------------
   // The low two bits select the latch, the upper twenty are its data.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            latch_r[i] <= `LATCH_RESET;
         end
      end else if (le_rise) begin
         if (shift_r[1:0] == `ADDR_AUX_REF) begin
            latch_r[`ADDR_AUX_REF] <= shift_r[`SHIFT_W-1:2];
         end else if (shift_r[1:0] == `ADDR_AUX_FB) begin
            latch_r[`ADDR_AUX_FB] <= shift_r[`SHIFT_W-1:2];
         end else if (shift_r[1:0] == `ADDR_MAIN_REF) begin
            latch_r[`ADDR_MAIN_REF] <= shift_r[`SHIFT_W-1:2];
         end else begin
            latch_r[`ADDR_MAIN_FB] <= shift_r[`SHIFT_W-1:2];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Per-loop configuration
   // ----------------------------------------------------------------------------
   logic [1:0]  pd;
   logic [1:0]  pol;
   logic [1:0]  boost;
   logic [`MF_SEL_W-1:0] mf_sel;

   // Power-down bits live in the feedback latches.
   assign pd[`LOOP_AUX]     = latch_r[`ADDR_AUX_FB][`F_PD];
   assign pd[`LOOP_MAIN]    = latch_r[`ADDR_MAIN_FB][`F_PD];
   assign pol[`LOOP_AUX]    = latch_r[`ADDR_AUX_REF][`F_POL];
   assign pol[`LOOP_MAIN]   = latch_r[`ADDR_MAIN_REF][`F_POL];
   assign boost[`LOOP_AUX]  = latch_r[`ADDR_AUX_REF][`F_BOOST];
   assign boost[`LOOP_MAIN] = latch_r[`ADDR_MAIN_REF][`F_BOOST];

   // The main reference latch holds the upper half of the select code.
   assign mf_sel = {latch_r[`ADDR_MAIN_REF][`F_MF_HI:`F_MF_LO],
                    latch_r[`ADDR_AUX_REF][`F_MF_HI:`F_MF_LO]};

   // ----------------------------------------------------------------------------
   // Reference input block
   // ----------------------------------------------------------------------------
   logic ref_prev_r;
   logic ref_on;
   logic ref_edge;
   logic ref_en_r;

   // The reference pin is released only when both loops sleep.
   assign ref_on   = ~(pd[`LOOP_MAIN] & pd[`LOOP_AUX]);
   assign ref_edge = reference_input & ~ref_prev_r & ref_on;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ref_prev_r <= 1'b0;
         ref_en_r   <= 1'b1;
      end else begin
         ref_prev_r <= reference_input & ref_on;
         ref_en_r   <= ref_on;
      end
   end

   assign reference_input_enable = ref_en_r;

   // ----------------------------------------------------------------------------
   // Loops: reference divider, detector, pump and lock detect
   // ----------------------------------------------------------------------------
   logic [1:0] ref_pulse_r;
   logic [1:0] fb_pulse;
   logic [1:0] up_r;
   logic [1:0] down_r;
   logic [1:0] boost_r;
   logic [1:0] lock_r;
   logic [1:0] rf_en_r;

   for (genvar l = 0; l < 2; l++) begin : g_loop
      logic [`REF_CNT_W-1:0] ref_cnt_r;
      pfd_state_t            state_r;
      pfd_state_t            state_nxt;
      logic [`DATA_W-1:0]    fb_cfg;
      fb_div_if              fbi ();

      // Each feedback divider sees only its own loop's latch.
      assign fb_cfg        = latch_r[{l[0], 1'b1}];
      assign fbi.hold      = pd[l];
      assign fbi.psel      = fb_cfg[`F_PSEL];
      assign fbi.int_ratio = fb_cfg[`F_INT_HI:`F_INT_LO];
      assign fbi.swallow   = fb_cfg[`F_SWL_HI:0];
      assign fb_pulse[l]   = fbi.fb_pulse;

      fb_divider #(
         .HIGH_RATE (l == `LOOP_MAIN ? MAIN_HIGH_RATE : AUX_HIGH_RATE)
      ) u_fb (
         .sys_clk  (sys_clk),
         .rst      (rst),
         .rf_input (l == `LOOP_MAIN ? main_rf_input : aux_rf_input),
         .dv       (fbi.div)
      );

      // Both dividers leave reset in the same cycle, so they restart aligned.
      // A ratio lowered below the current count ends that period at the next reference edge.
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            ref_cnt_r      <= '0;
            ref_pulse_r[l] <= 1'b0;
         end else if (pd[l]) begin
            ref_cnt_r      <= '0;
            ref_pulse_r[l] <= 1'b0;
         end else if (ref_edge) begin
            if (ref_cnt_r >= ref_ratio(latch_r[{l[0], 1'b0}]) - `REF_CNT_W'(1)) begin
               ref_cnt_r      <= '0;
               ref_pulse_r[l] <= 1'b1;
            end else begin
               ref_cnt_r      <= ref_cnt_r + `REF_CNT_W'(1);
               ref_pulse_r[l] <= 1'b0;
            end
         end else begin
            ref_pulse_r[l] <= 1'b0;
         end
      end

      // Phase/frequency detector: whichever edge arrives first holds the
      // pump on until the other edge arrives.
      always_comb begin
         state_nxt = state_r;
         case (state_r)
            PFD_IDLE: begin
               if (ref_pulse_r[l] & ~fb_pulse[l]) begin
                  state_nxt = PFD_REF_LEAD;
               end else if (fb_pulse[l] & ~ref_pulse_r[l]) begin
                  state_nxt = PFD_FB_LEAD;
               end
            end
            PFD_REF_LEAD: begin
               if (fb_pulse[l]) begin
                  state_nxt = PFD_IDLE;
               end
            end
            PFD_FB_LEAD: begin
               if (ref_pulse_r[l]) begin
                  state_nxt = PFD_IDLE;
               end
            end
            default: begin
               state_nxt = PFD_IDLE;
            end
         endcase
         // Power-down forces the detector back to idle.
         if (pd[l]) begin
            state_nxt = PFD_IDLE;
         end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            state_r <= PFD_IDLE;
         end else begin
            state_r <= state_nxt;
         end
      end

      // A set polarity bit pumps up when the reference leads.
      // Lock reads high while the pump idles or the loop sleeps.
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            up_r[l]    <= 1'b0;
            down_r[l]  <= 1'b0;
            boost_r[l] <= 1'b0;
            lock_r[l]  <= 1'b1;
            rf_en_r[l] <= 1'b1;
         end else begin
            up_r[l]    <= pol[l] ? (state_nxt == PFD_REF_LEAD) : (state_nxt == PFD_FB_LEAD);
            down_r[l]  <= pol[l] ? (state_nxt == PFD_FB_LEAD) : (state_nxt == PFD_REF_LEAD);
            boost_r[l] <= boost[l] & ~pd[l];
            lock_r[l]  <= pd[l] | ~pump_active(state_nxt);
            rf_en_r[l] <= ~pd[l];
         end
      end
   end

   assign main_pump_up            = up_r[`LOOP_MAIN];
   assign main_pump_down          = down_r[`LOOP_MAIN];
   assign main_pump_current_boost = boost_r[`LOOP_MAIN];
   assign aux_pump_up             = up_r[`LOOP_AUX];
   assign aux_pump_down           = down_r[`LOOP_AUX];
   assign aux_pump_current_boost  = boost_r[`LOOP_AUX];
   assign main_rf_input_enable    = rf_en_r[`LOOP_MAIN];
   assign aux_rf_input_enable     = rf_en_r[`LOOP_AUX];

   // ----------------------------------------------------------------------------
   // Multifunction output
   // ----------------------------------------------------------------------------
   // Open-drain modes only ever drive low; CMOS modes drive both levels.
   logic mf_o_nxt;
   logic mf_oe_nxt;
   logic mf_o_r;
   logic mf_oe_r;

   // Status modes pass the one-cycle divider pulses through.
   always_comb begin
      mf_o_nxt  = 1'b0;
      mf_oe_nxt = 1'b1;
      case (mf_sel)
         `MF_CMOS_HIGH: mf_o_nxt = 1'b1;
         `MF_LD_MAIN:   mf_oe_nxt = ~lock_r[`LOOP_MAIN];
         `MF_LD_AUX:    mf_oe_nxt = ~lock_r[`LOOP_AUX];
         `MF_LD_BOTH:   mf_oe_nxt = ~(lock_r[`LOOP_MAIN] & lock_r[`LOOP_AUX]);
         `MF_REF_MAIN:  mf_o_nxt = ref_pulse_r[`LOOP_MAIN];
         `MF_FB_MAIN:   mf_o_nxt = fb_pulse[`LOOP_MAIN];
         `MF_REF_AUX:   mf_o_nxt = ref_pulse_r[`LOOP_AUX];
         `MF_FB_AUX:    mf_o_nxt = fb_pulse[`LOOP_AUX];
         `MF_FAST_MAIN: mf_oe_nxt = boost[`LOOP_MAIN] & ~pd[`LOOP_MAIN];
         `MF_FAST_AUX:  mf_oe_nxt = boost[`LOOP_AUX] & ~pd[`LOOP_AUX];
         default:       mf_o_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mf_o_r  <= 1'b0;
         mf_oe_r <= 1'b1;
      end else begin
         mf_o_r  <= mf_o_nxt;
         mf_oe_r <= mf_oe_nxt;
      end
   end

   assign multifunction_output_o  = mf_o_r;
   assign multifunction_output_oe = mf_oe_r;

endmodule
`default_nettype wire

// [dual_pll_synth_control_test.sv]
// Self-checking testbench of the synthesizer control core.
`default_nettype none
module dual_pll_synth_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic reference_input = 1'b0;
   logic main_rf_input = 1'b0;
   logic aux_rf_input = 1'b0;
   wire  serial_clock;
   wire  serial_data;
   wire  load_strobe;
   logic mp_up, mp_dn, mp_bst, ap_up, ap_dn, ap_bst, m_en, a_en, r_en, mf_o, mf_oe;
   int   fails = 0;
   int   total_checks = 0;
   int   n;
   dual_pll_synth_control i_dut (.sys_clk, .rst, .reference_input, .main_rf_input, .aux_rf_input,
      .serial_clock, .serial_data, .load_strobe, .main_pump_up(mp_up), .main_pump_down(mp_dn),
      .main_pump_current_boost(mp_bst), .aux_pump_up(ap_up), .aux_pump_down(ap_dn),
      .aux_pump_current_boost(ap_bst), .main_rf_input_enable(m_en), .aux_rf_input_enable(a_en),
      .reference_input_enable(r_en), .multifunction_output_o(mf_o), .multifunction_output_oe(mf_oe));
   serial_host_model i_host (.sys_clk, .serial_clock, .serial_data, .load_strobe);
   always #2 sys_clk = ~sys_clk;
   // The main RF input stays still so that its reference always leads.
   always @(negedge sys_clk) begin
      reference_input <= ~reference_input;
      aux_rf_input <= ~aux_rf_input;
   end
   // -------------------------------------------------------------
   // Access and compare tasks
   // -------------------------------------------------------------
   function automatic logic [21:0] refw(input logic [1:0] mf, input logic b, p, input logic [14:0] r,
                                        input logic [1:0] a);
      return {mf, 1'b0, b, p, r, a};
   endfunction
   function automatic logic [21:0] fbw(input logic pd, ps, input logic [12:0] b, input logic [4:0] s,
                                       input logic [1:0] a);
      return {pd, ps, b, s, a};
   endfunction
   task automatic chk(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [21:0] w);
      i_host.send(w, 1'b1);
      repeat (4) @(negedge sys_clk);
   endtask
   // Counts cycles between two pulses on the multifunction pin.
   task automatic per(output int k);
      int g;
      g = 0;
      while (mf_o !== 1'b1 && g < 3000) begin
         @(negedge sys_clk);
         g++;
      end
      k = 0;
      do begin
         @(negedge sys_clk);
         k++;
      end while (mf_o !== 1'b1 && k < 3000);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      wrap_up();
   end
   // -------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------
   initial begin
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      chk(mf_oe, 1'b1); chk(mf_o, 1'b0); chk(r_en, 1'b1); chk(mp_bst, 1'b0);
      $display("test reset done");
      wr(refw(2'h1, 1'b0, 1'b1, 15'h0002, 2'h2));
      wr(refw(2'h3, 1'b0, 1'b1, 15'h0005, 2'h0));
      per(n);
      per(n);
      chk_n(n, 2 * 5);
      $display("test reference ratio done");
      wr(refw(2'h2, 1'b0, 1'b1, 15'h0002, 2'h2));
      wr(refw(2'h0, 1'b0, 1'b1, 15'h0005, 2'h0));
      wr(fbw(1'b0, 1'b1, 13'h0003, 5'h01, 2'h1));
      per(n);
      per(n);
      chk_n(n, 2 * (8 * 3 + 1));
      wr(fbw(1'b0, 1'b0, 13'h0002, 5'h01, 2'h1));
      per(n);
      per(n);
      chk_n(n, 2 * (16 * 2 + 1));
      $display("test feedback ratio done");
      wr(refw(2'h0, 1'b0, 1'b1, 15'h0002, 2'h2));
      wr(refw(2'h2, 1'b0, 1'b1, 15'h0005, 2'h0));
      repeat (20) @(negedge sys_clk);
      chk(mp_up, 1'b1); chk(mp_dn, 1'b0); chk(mf_oe, 1'b1); chk(mf_o, 1'b0);
      wr(refw(2'h2, 1'b1, 1'b0, 15'h0002, 2'h2));
      wr(refw(2'h1, 1'b0, 1'b1, 15'h0005, 2'h0));
      repeat (20) @(negedge sys_clk);
      chk(mp_dn, 1'b1); chk(mp_up, 1'b0); chk(mp_bst, 1'b1); chk(ap_bst, 1'b0);
      chk(mf_oe, 1'b1); chk(mf_o, 1'b0);
      $display("test pump done");
      wr(fbw(1'b1, 1'b0, 13'h0000, 5'h00, 2'h3));
      chk(m_en, 1'b0); chk(mp_bst, 1'b0); chk(mp_dn, 1'b0); chk(mf_oe, 1'b0); chk(r_en, 1'b1);
      wr(refw(2'h0, 1'b1, 1'b0, 15'h0002, 2'h2));
      wr(refw(2'h2, 1'b0, 1'b1, 15'h0005, 2'h0));
      chk(mf_oe, 1'b0);
      i_host.send(refw(2'h1, 1'b0, 1'b1, 15'h0005, 2'h0), 1'b0);
      repeat (4) @(negedge sys_clk);
      chk(mf_oe, 1'b0); chk(mf_o, 1'b0);
      wr(fbw(1'b1, 1'b0, 13'h0000, 5'h00, 2'h1));
      chk(r_en, 1'b0); chk(a_en, 1'b0); chk(ap_up, 1'b0); chk(ap_dn, 1'b0);
      $display("test power down done");
      wr(fbw(1'b0, 1'b0, 13'h0000, 5'h00, 2'h3));
      chk(r_en, 1'b1); chk(m_en, 1'b1);
      wr(refw(2'h1, 1'b0, 1'b1, 15'h0005, 2'h0));
      chk(mf_o, 1'b1); chk(mf_oe, 1'b1);
      wr(refw(2'h1, 1'b1, 1'b0, 15'h0002, 2'h2));
      per(n);
      per(n);
      chk_n(n, 2 * 2);
      $display("test power up done");
      wrap_up();
   end
endmodule
`default_nettype wire

// [fb_div_if.sv]
// Carrier between a loop's control logic and its feedback divider.
`include "synth_defines.svh"
`default_nettype none
interface fb_div_if;
   logic                    hold;
   logic                    psel;
   logic [`INT_CNT_W-1:0]   int_ratio;
   logic [`SWALLOW_W-1:0]   swallow;
   logic                    fb_pulse;
   modport ctrl (output hold, output psel, output int_ratio, output swallow, input fb_pulse);
   modport div  (input hold, input psel, input int_ratio, input swallow, output fb_pulse);
endinterface
`default_nettype wire

// [fb_divider.sv]
// Dual-modulus prescaler and integer plus swallow feedback counter of one loop.
`include "synth_defines.svh"
`default_nettype none
module fb_divider
   import synth_pkg::*;
#(
   parameter bit HIGH_RATE = 1'b1
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic rf_input,
   fb_div_if.div     dv
);
   logic                  rf_prev_r;
   logic [`PRE_CNT_W-1:0] pre_cnt_r;
   logic [`INT_CNT_W-1:0] int_cnt_r;
   logic [`SWALLOW_W-1:0] swl_cnt_r;
   logic                  fb_pulse_r;
   logic [`PRE_CNT_W-1:0] modulus;
   logic                  rf_edge;
   logic                  pre_tick;

   // ----------------------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------------------
   // The upper modulus is used while swallow cycles remain in this period.
   always_comb begin
      if (HIGH_RATE) begin
         modulus = dv.psel ? `MOD_16 : `MOD_32;
      end else begin
         modulus = dv.psel ? `MOD_8 : `MOD_16;
      end
      if (swl_cnt_r != '0) begin
         modulus = modulus + `PRE_CNT_W'(1);
      end
   end

   assign rf_edge  = rf_input & ~rf_prev_r & ~dv.hold;
   assign pre_tick = rf_edge & (pre_cnt_r >= modulus - `PRE_CNT_W'(1));

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rf_prev_r <= 1'b0;
      end else begin
         rf_prev_r <= rf_input;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pre_cnt_r <= '0;
      end else if (dv.hold) begin
         pre_cnt_r <= '0;
      end else if (pre_tick) begin
         pre_cnt_r <= '0;
      end else if (rf_edge) begin
         pre_cnt_r <= pre_cnt_r + `PRE_CNT_W'(1);
      end
   end

   // ----------------------------------------------------------------------------
   // Feedback counter, clocked by prescaler output ticks
   // ----------------------------------------------------------------------------
   // Total ratio is modulus times the integer ratio plus the swallow count.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         int_cnt_r  <= '0;
         swl_cnt_r  <= '0;
         fb_pulse_r <= 1'b0;
      end else if (dv.hold) begin
         int_cnt_r  <= '0;
         swl_cnt_r  <= dv.swallow;
         fb_pulse_r <= 1'b0;
      end else if (pre_tick) begin
         if (int_cnt_r >= dv.int_ratio - `INT_CNT_W'(1)) begin
            int_cnt_r  <= '0;
            swl_cnt_r  <= dv.swallow;
            fb_pulse_r <= 1'b1;
         end else begin
            int_cnt_r  <= int_cnt_r + `INT_CNT_W'(1);
            fb_pulse_r <= 1'b0;
            if (swl_cnt_r != '0) begin
               swl_cnt_r <= swl_cnt_r - `SWALLOW_W'(1);
            end
         end
      end else begin
         fb_pulse_r <= 1'b0;
      end
   end

   assign dv.fb_pulse = fb_pulse_r;
endmodule
`default_nettype wire

// [serial_host_model.sv]
// Host side model that shifts words into the serial port.
`default_nettype none
module serial_host_model (
   input  wire logic sys_clk,
   output var  logic serial_clock = 1'b0,
   output var  logic serial_data  = 1'b0,
   output var  logic load_strobe  = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   // -------------------------------------------------------------
   // Word transfer
   // -------------------------------------------------------------
   task automatic send(input logic [21:0] w, input logic load);
      for (int i = 21; i >= 0; i--) begin
         @(negedge sys_clk);
         serial_data = w[i];
         serial_clock = 1'b0;
         @(negedge sys_clk);
         serial_clock = 1'b1;
      end
      @(negedge sys_clk);
      serial_clock = 1'b0;
      // The data line is no longer held, so it shows a wrong value.
      serial_data = ~serial_data;
      if (load) begin
         @(negedge sys_clk);
         load_strobe = 1'b1;
         @(negedge sys_clk);
         load_strobe = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// [synth_ctrl_assertions.sv]
// Concurrent checks on the ports of the synthesizer control core.
`default_nettype none
module synth_ctrl_assertions (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load_strobe,
   input wire logic main_pump_up,
   input wire logic main_pump_down,
   input wire logic main_pump_current_boost,
   input wire logic aux_pump_up,
   input wire logic aux_pump_down,
   input wire logic aux_pump_current_boost,
   input wire logic main_rf_input_enable,
   input wire logic aux_rf_input_enable,
   input wire logic reference_input_enable,
   input wire logic multifunction_output_o,
   input wire logic multifunction_output_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] load_hist_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         load_hist_r <= 3'h0;
      end else begin
         load_hist_r <= {load_hist_r[1:0], load_strobe};
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence rst_release;
      $fell(rst);
   endsequence
   sequence main_pd_held;
      !main_rf_input_enable [*3];
   endsequence
   sequence aux_pd_held;
      !aux_rf_input_enable [*3];
   endsequence
   reset_idle_a: assert property (rst_release |-> reference_input_enable && main_rf_input_enable
      && multifunction_output_oe && !multifunction_output_o && !main_pump_up) else $error("bad idle state");
   main_pump_excl_a: assert property (!(main_pump_up && main_pump_down)) else $error("main pump both ways");
   aux_pump_excl_a: assert property (!(aux_pump_up && aux_pump_down)) else $error("aux pump both ways");
   main_pd_quiet_a: assert property (main_pd_held |-> !main_pump_up && !main_pump_down
      && !main_pump_current_boost) else $error("main pump active while down");
   aux_pd_quiet_a: assert property (aux_pd_held |-> !aux_pump_up && !aux_pump_down
      && !aux_pump_current_boost) else $error("aux pump active while down");
   ref_pd_both_a: assert property ($fell(reference_input_enable) |-> !main_rf_input_enable
      && !aux_rf_input_enable) else $error("reference off with a loop up");
   main_boost_hold_a: assert property ($changed(main_pump_current_boost) |-> (|load_hist_r))
      else $error("main boost changed without load");
   aux_boost_hold_a: assert property ($changed(aux_pump_current_boost) |-> (|load_hist_r))
      else $error("aux boost changed without load");
endmodule
bind dual_pll_synth_control synth_ctrl_assertions i_chk (.sys_clk, .rst, .load_strobe, .main_pump_up,
   .main_pump_down, .main_pump_current_boost, .aux_pump_up, .aux_pump_down, .aux_pump_current_boost,
   .main_rf_input_enable, .aux_rf_input_enable, .reference_input_enable, .multifunction_output_o,
   .multifunction_output_oe);
`default_nettype wire

// [synth_defines.svh]
// Constants for the dual synthesizer control core.
`ifndef SYNTH_DEFINES_SVH
`define SYNTH_DEFINES_SVH
// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define SHIFT_W       22
`define DATA_W        20
`define REF_CNT_W     15
`define INT_CNT_W     13
`define SWALLOW_W     5
`define PRE_CNT_W     6
`define MF_SEL_W      4
// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define LATCH_RESET   20'h00000
`define REF_RATIO_MIN 15'h0002
// ----------------------------------------------------------------------------
// Latch addresses and loop indices
// ----------------------------------------------------------------------------
`define ADDR_AUX_REF  2'h0
`define ADDR_AUX_FB   2'h1
`define ADDR_MAIN_REF 2'h2
`define ADDR_MAIN_FB  2'h3
`define LOOP_AUX      0
`define LOOP_MAIN     1
// ----------------------------------------------------------------------------
// Field positions inside the 20-bit data field
// ----------------------------------------------------------------------------
`define F_MF_HI       19
`define F_MF_LO       18
`define F_BOOST       16
`define F_POL         15
`define F_RCNT_HI     14
`define F_PD          19
`define F_PSEL        18
`define F_INT_HI      17
`define F_INT_LO      5
`define F_SWL_HI      4
// ----------------------------------------------------------------------------
// Prescaler lower moduli (upper modulus is one more)
// ----------------------------------------------------------------------------
`define MOD_32        6'h20
`define MOD_16        6'h10
`define MOD_8         6'h08
// ----------------------------------------------------------------------------
// Multifunction output select codes
// ----------------------------------------------------------------------------
`define MF_CMOS_LOW   4'h0
`define MF_CMOS_HIGH  4'h1
`define MF_LD_MAIN    4'h2
`define MF_LD_AUX     4'h3
`define MF_LD_BOTH    4'h4
`define MF_REF_MAIN   4'h5
`define MF_FB_MAIN    4'h6
`define MF_REF_AUX    4'h7
`define MF_FB_AUX     4'h8
`define MF_FAST_MAIN  4'h9
`define MF_FAST_AUX   4'hA
`endif

// [synth_pkg.sv]
// Types shared by the dual synthesizer control core.
`default_nettype none
package synth_pkg;
   typedef enum logic [1:0] {
      PFD_IDLE     = 2'b00,
      PFD_REF_LEAD = 2'b01,
      PFD_FB_LEAD  = 2'b10
   } pfd_state_t;
endpackage
`default_nettype wire
